// File: pkg/pin_regs_defines.svh
`ifndef PIN_REGS_DEFINES_SVH
`define PIN_REGS_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PIN_CTRL_ADDR      7'h0e
`define PIN_OUT_ADDR       7'h0f
`define PIN_IN_ADDR        7'h10
`define PREBUF_LOW_ADDR    7'h11
`define PREBUF_HIGH_ADDR   7'h12

// ----------------------------------------
// Fields
// ----------------------------------------
`define PIN_ENABLE_BIT     7
`define PIN_COUNT          5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PIN_CTRL_RESET     8'h00
`define PIN_OUT_RESET      8'h00
`define PIN_IN_RESET       8'h00
`define PREBUF_RESET       8'hff

`endif

// File: pkg/pin_regs_pkg.sv
package pin_regs_pkg;
   // Register access request from the serial control front end
   typedef struct packed {
      logic       wr;
      logic [6:0] addr;
      logic [7:0] data;
   } reg_req_t;

   // User pin bundle: level out, enable out
   typedef struct packed {
      logic [4:0] level;
      logic [4:0] drive;
   } pin_drive_t;
endpackage

// File: logic/user_pin_and_prebuffer_regs.sv
// How it works
// - Control bit 1 sets pin 1 direction
// - Control bit 0 sets pin 0 direction
// - Control bits 4..2 set pins 4..2 direction
// - Control bit 7 enables pins, SPI mode only
// - Output levels register at 0x0f, reset zero
// - Bit n maps straight to pin n
// - Input levels register at 0x10 samples inputs
// - Low precharge register 0x11, resets 0xff
// - High precharge register 0x12, resets 0xff
// - Bit 2k positive, 2k+1 negative buffer
// - Precharge writes store inverted byte
`timescale 1ns/10ps
`include "pin_regs_defines.svh"

module user_pin_and_prebuffer_regs (
   input  wire logic                      sys_clk_in,
   input  wire logic                      rst_n_in,
   input  wire pin_regs_pkg::reg_req_t    req_in,
   input  wire logic                      req_valid_in,
   input  wire logic                      spi_mode_in,
   input  wire logic [4:0]                pin_level_in,
   output      pin_regs_pkg::pin_drive_t  pin_out,
   output      logic [7:0]                rd_data_out,
   output      logic [7:0]                pos_precharge_on_out,
   output      logic [7:0]                neg_precharge_on_out
);

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   logic [7:0] pin_ctrl_r;
   logic [7:0] pin_out_r;
   logic [7:0] pin_in_r;
   logic [7:0] prebuf_low_r;
   logic [7:0] prebuf_high_r;
   logic [7:0] rd_data_nxt;
   logic       wr_en;
   logic       pins_live;

   assign wr_en     = req_valid_in && req_in.wr;
   // Pins only usable in SPI control mode with the global enable set
   assign pins_live = pin_ctrl_r[`PIN_ENABLE_BIT] && spi_mode_in;

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         pin_ctrl_r <= `PIN_CTRL_RESET;
      end else if (wr_en && req_in.addr == `PIN_CTRL_ADDR) begin
         // Bits 6..5 are reserved and read as zero
         pin_ctrl_r <= {req_in.data[7], 2'h0, req_in.data[4:0]};
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         pin_out_r <= `PIN_OUT_RESET;
      end else if (wr_en && req_in.addr == `PIN_OUT_ADDR) begin
         pin_out_r <= {3'h0, req_in.data[4:0]};
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         prebuf_low_r  <= `PREBUF_RESET;
         prebuf_high_r <= `PREBUF_RESET;
      end else if (wr_en) begin
         // Host writes the complement of the wanted settings
         if (req_in.addr == `PREBUF_LOW_ADDR) begin
            prebuf_low_r <= ~req_in.data;
         end
         if (req_in.addr == `PREBUF_HIGH_ADDR) begin
            prebuf_high_r <= ~req_in.data;
         end
      end
   end

   // ----------------------------------------
   // Per-pin sampling and drive
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < `PIN_COUNT; i++) begin : g_pin
         logic drive_en;
         // Output pins keep their last sampled value rather than echo themselves
         assign drive_en = pins_live && pin_ctrl_r[i];
         always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
               pin_in_r[i] <= 1'b0;
            end else if (pins_live && !pin_ctrl_r[i]) begin
               pin_in_r[i] <= pin_level_in[i];
            end
         end
         always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
               pin_out.level[i] <= 1'b0;
               pin_out.drive[i] <= 1'b0;
            end else begin
               pin_out.level[i] <= pin_out_r[i];
               pin_out.drive[i] <= drive_en;
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         pin_in_r[7:5] <= 3'h0;
      end else begin
         pin_in_r[7:5] <= 3'h0;
      end
   end

   // ----------------------------------------
   // Precharge outputs
   // ----------------------------------------
   generate
      for (i = 0; i < 4; i++) begin : g_chan
         always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
               pos_precharge_on_out[i]     <= 1'b1;
               neg_precharge_on_out[i]     <= 1'b1;
               pos_precharge_on_out[i + 4] <= 1'b1;
               neg_precharge_on_out[i + 4] <= 1'b1;
            end else begin
               pos_precharge_on_out[i]     <= prebuf_low_r[2 * i];
               neg_precharge_on_out[i]     <= prebuf_low_r[2 * i + 1];
               pos_precharge_on_out[i + 4] <= prebuf_high_r[2 * i];
               neg_precharge_on_out[i + 4] <= prebuf_high_r[2 * i + 1];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   always_comb begin
      case (req_in.addr)
         `PIN_CTRL_ADDR:    rd_data_nxt = pin_ctrl_r;
         `PIN_OUT_ADDR:     rd_data_nxt = pin_out_r;
         `PIN_IN_ADDR:      rd_data_nxt = pin_in_r;
         `PREBUF_LOW_ADDR:  rd_data_nxt = prebuf_low_r;
         `PREBUF_HIGH_ADDR: rd_data_nxt = prebuf_high_r;
         default:           rd_data_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         rd_data_out <= 8'h00;
      end else if (req_valid_in && !req_in.wr) begin
         rd_data_out <= rd_data_nxt;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);

   prebuf_low_inv_a: assert property (
      wr_en && req_in.addr == `PREBUF_LOW_ADDR |=> prebuf_low_r == ~$past(req_in.data))
      else $error("low precharge not inverted");
   prebuf_high_inv_a: assert property (
      wr_en && req_in.addr == `PREBUF_HIGH_ADDR |=> prebuf_high_r == ~$past(req_in.data))
      else $error("high precharge not inverted");
   no_drive_off_a: assert property (
      !pins_live |=> pin_out.drive == 5'h00)
      else $error("pin driven while disabled");
   drive_dir_a: assert property (
      pins_live |=> pin_out.drive == $past(pin_ctrl_r[4:0]))
      else $error("drive does not follow direction");
   out_level_a: assert property (
      wr_en && req_in.addr == `PIN_OUT_ADDR |=> ##1 pin_out.level == $past(req_in.data[4:0], 2))
      else $error("output level mismatch");
   in_sample_a: assert property (
      pins_live && !pin_ctrl_r[0] |=> pin_in_r[0] == $past(pin_level_in[0]))
      else $error("input not sampled");
   in_hold_a: assert property (
      pin_ctrl_r[2] |=> $stable(pin_in_r[2]))
      else $error("output pin sampled");
   precharge_map_a: assert property (
      ##1 neg_precharge_on_out[5] == $past(prebuf_high_r[3]))
      else $error("precharge bit map wrong");
   ctrl_reserved_a: assert property (
      pin_ctrl_r[6:5] == 2'h0)
      else $error("reserved control bits set");
   ctrl_write_a: assert property (
      wr_en && req_in.addr == `PIN_CTRL_ADDR |=> pin_ctrl_r == {$past(req_in.data[7]), 2'h0, $past(req_in.data[4:0])})
      else $error("control write not stored");
   out_reg_a: assert property (
      wr_en && req_in.addr == `PIN_OUT_ADDR |=> pin_out_r == {3'h0, $past(req_in.data[4:0])})
      else $error("output levels write not stored");
   in_frozen_a: assert property (
      !pins_live |=> $stable(pin_in_r))
      else $error("input sampled while pins off");
   rd_in_a: assert property (
      req_valid_in && !req_in.wr && req_in.addr == `PIN_IN_ADDR |=> rd_data_out == $past(pin_in_r))
      else $error("input levels read wrong");
   rd_prebuf_a: assert property (
      req_valid_in && !req_in.wr && req_in.addr == `PREBUF_HIGH_ADDR |=> rd_data_out == $past(prebuf_high_r))
      else $error("high precharge read wrong");

   // Whole bit maps every cycle, so one stuck or swapped output cannot hide
   pos_map_a: assert property (
      1'b1 |=> pos_precharge_on_out == $past({prebuf_high_r[6], prebuf_high_r[4], prebuf_high_r[2],
         prebuf_high_r[0], prebuf_low_r[6], prebuf_low_r[4], prebuf_low_r[2], prebuf_low_r[0]}))
      else $error("positive precharge map wrong");
   neg_map_a: assert property (
      1'b1 |=> neg_precharge_on_out == $past({prebuf_high_r[7], prebuf_high_r[5], prebuf_high_r[3],
         prebuf_high_r[1], prebuf_low_r[7], prebuf_low_r[5], prebuf_low_r[3], prebuf_low_r[1]}))
      else $error("negative precharge map wrong");
   level_follow_a: assert property (
      1'b1 |=> pin_out.level == $past(pin_out_r[4:0]))
      else $error("pin level does not follow register");

   pins_on_c: cover property (pins_live && pin_ctrl_r[0]);
   prebuf_wr_c: cover property (wr_en && req_in.addr == `PREBUF_LOW_ADDR);
   in_read_c: cover property (req_valid_in && !req_in.wr && req_in.addr == `PIN_IN_ADDR);
   spi_off_c: cover property (pin_ctrl_r[`PIN_ENABLE_BIT] && !spi_mode_in);
   upper_out_c: cover property (pins_live && pin_ctrl_r[4:2] == 3'h7);

endmodule

// File: testbench/host_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Host side of the register request port
// ----------------------------------------
module host_model (
   input  wire logic                    sys_clk_in,
   output      pin_regs_pkg::reg_req_t  req_out,
   output      logic                    req_valid_out
);
   initial begin
      req_out = 16'h0000;
      req_valid_out = 1'b0;
   end
   // Held over the taking edge; data inverted after release so stale bytes never look valid
   task automatic access(input logic wr, input logic [6:0] addr, input logic [7:0] data);
      @(negedge sys_clk_in);
      req_out = {wr, addr, data};
      req_valid_out = 1'b1;
      @(negedge sys_clk_in);
      req_valid_out = 1'b0;
      req_out.data = ~data;
   endtask
endmodule

// File: testbench/tb.sv
`timescale 1ns/10ps
`include "pin_regs_defines.svh"
module tb;
   logic                      sys_clk_in = 1'b0;
   logic                      rst_n_in = 1'b0;
   logic                      spi_mode_in = 1'b1;
   logic [4:0]                pin_level_in = 5'h00;
   pin_regs_pkg::reg_req_t    req;
   logic                      req_valid;
   pin_regs_pkg::pin_drive_t  pins;
   logic [7:0]                rd_data;
   logic [7:0]                pos_on;
   logic [7:0]                neg_on;
   int                        err_count = 0;
   int                        comparisons = 0;

   always #5 sys_clk_in = ~sys_clk_in;

   host_model host_model_i (.sys_clk_in(sys_clk_in), .req_out(req), .req_valid_out(req_valid));
   user_pin_and_prebuffer_regs user_pin_and_prebuffer_regs_i (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
      .req_in(req), .req_valid_in(req_valid), .spi_mode_in(spi_mode_in), .pin_level_in(pin_level_in),
      .pin_out(pins), .rd_data_out(rd_data), .pos_precharge_on_out(pos_on), .neg_precharge_on_out(neg_on));

   // ----------------------------------------
   // Shared helpers
   // ----------------------------------------
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] exp);
      host_model_i.access(1'b0, a, 8'h00);
      check(rd_data, exp, "read");
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      host_model_i.access(1'b1, a, d);
      repeat (2) @(negedge sys_clk_in);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic test_reset();
      rd(`PIN_CTRL_ADDR, 8'h00);
      rd(`PIN_OUT_ADDR, 8'h00);
      rd(`PIN_IN_ADDR, 8'h00);
      rd(`PREBUF_LOW_ADDR, 8'hff);
      rd(`PREBUF_HIGH_ADDR, 8'hff);
      check(pos_on & neg_on, 8'hff, "buffers");
      check({3'h0, pins.drive}, 8'h00, "idle drive");
      check({3'h0, pins.level}, 8'h00, "idle level");
      $display("reset test done");
   endtask
   // Channel 0 positive and channel 7 negative switched off via inverted writes
   task automatic test_prebuf();
      wr(`PREBUF_LOW_ADDR, 8'h01);
      wr(`PREBUF_HIGH_ADDR, 8'h80);
      rd(`PREBUF_LOW_ADDR, 8'hfe);
      rd(`PREBUF_HIGH_ADDR, 8'h7f);
      check(pos_on, 8'hfe, "positive");
      check(neg_on, 8'h7f, "negative");
      $display("precharge test done");
   endtask
   // Pins 0,1 outputs, 2..4 inputs; then mode and enable pulled away
   task automatic test_pins();
      pin_level_in = 5'h0a;
      wr(`PIN_OUT_ADDR, 8'h15);
      wr(`PIN_CTRL_ADDR, 8'h83);
      check({3'h0, pins.drive}, 8'h03, "drive");
      check({3'h0, pins.level & pins.drive}, 8'h01, "level");
      check({3'h0, pins.level}, 8'h15, "levels");
      rd(`PIN_IN_ADDR, 8'h08);
      wr(`PIN_IN_ADDR, 8'hff);
      rd(`PIN_IN_ADDR, 8'h08);
      rd(`PIN_OUT_ADDR, 8'h15);
      @(negedge sys_clk_in) spi_mode_in = 1'b0;
      repeat (2) @(negedge sys_clk_in);
      check({3'h0, pins.drive}, 8'h00, "no spi");
      spi_mode_in = 1'b1;
      wr(`PIN_CTRL_ADDR, 8'h1f);
      check({3'h0, pins.drive}, 8'h00, "disabled");
      pin_level_in = 5'h1f;
      rd(`PIN_IN_ADDR, 8'h08);
      wr(`PIN_CTRL_ADDR, 8'h9c);
      check({3'h0, pins.drive}, 8'h1c, "upper drive");
      rd(`PIN_IN_ADDR, 8'h0b);
      $display("pin test done");
   endtask

   initial begin
      repeat (10) @(negedge sys_clk_in);
      rst_n_in = 1'b1;
      test_reset();
      test_prebuf();
      test_pins();
      give_verdict();
   end
   // Whole run is well under 200 cycles
   initial begin
      #20000;
      err_count++;
      give_verdict();
   end
endmodule
